// ===== logic/pmpr_pkg.sv
// Purpose: Shared constants and carrier types for the precision-mode page register group.
// Assumes: One register access per clock through the word-wide register port.
// Notes: Offsets are the byte addresses of the 24-bit and 8-bit registers.
package pmpr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 24;
  localparam int CODE_W = 16;
  localparam int NUM_CH = 2;
  localparam int CODE_LO = 8;
  localparam int CODE_HI = 23;
  localparam int SELECT_ZERO_BIT = 0;
  localparam int SELECT_ONE_BIT = 1;
  localparam int CTRL_W = 2;

  localparam logic [ADDR_W-1:0] OFS_STROBE_MASK = 8'h37;
  localparam logic [ADDR_W-1:0] OFS_CH0_OUTPUT = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_CH1_OUTPUT = 8'h3b;
  localparam logic [ADDR_W-1:0] OFS_BCAST_OUTPUT = 8'h3e;
  localparam logic [ADDR_W-1:0] OFS_CH_SELECT = 8'h41;
  localparam logic [ADDR_W-1:0] OFS_BCAST_STAGED = 8'h42;
  localparam logic [ADDR_W-1:0] OFS_SOFT_LOAD = 8'h45;
  localparam logic [ADDR_W-1:0] OFS_CH0_STAGED = 8'h46;
  localparam logic [ADDR_W-1:0] OFS_CH1_STAGED = 8'h49;

  localparam logic [ADDR_W-1:0] OFS_OUTPUT [NUM_CH] = '{8'h38, 8'h3b};
  localparam logic [ADDR_W-1:0] OFS_STAGED [NUM_CH] = '{8'h46, 8'h49};

  localparam logic [CODE_W-1:0] RST_CODE = 16'h0000;
  localparam logic [CTRL_W-1:0] RST_CTRL = 2'h0;
  localparam logic [DATA_W-1:0] RST_WORD = 24'h000000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pmpr_req_type;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } pmpr_rsp_type;
endpackage

// ===== logic/pmpr_regs.sv
// Purpose: Precision-mode channel code registers with output and staged broadcast pages.
// Assumes: Register port is already deframed from the serial link; strobe is synchronous.
// Notes: A direct or page write to an output register wins over a same-cycle load.
`timescale 1ns/1ps
`default_nettype none

// Function
// R01: Channel 1 output code is a readable, writable 24-bit word, code in 23:8, reset zero.
// R02: An output page write copies its code to every selected channel output register.
// R03: With both selects set one output page write updates both channels together.
// R04: Channel select decides page targets; reset zero selects no channel.
// R05: Select bit 1 routes page data to channel 1 staged and output registers.
// R06: Select bit 0 routes page data to channel 0 staged and output registers.
// R07: A staged page write copies its code to selected staged registers only.
// R08: A soft load write moves staged codes into output registers like the strobe.
// R09: Soft load bit 1 loads channel 1, bit 0 channel 0, self-clearing, zero ignored.
// R10: Load strobe falling edge latches staged into output unless the channel is masked.
// R11: Reserved low byte and upper bits read zero and ignore writes.
module pmpr_regs (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire pmpr_pkg::pmpr_req_type req_in,
  input wire logic load_strobe_n_in,
  output pmpr_pkg::pmpr_rsp_type rsp_out,
  output logic [pmpr_pkg::CODE_W-1:0] channel0_code_out,
  output logic [pmpr_pkg::CODE_W-1:0] channel1_output_code_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode.

  function automatic logic hit(input pmpr_pkg::pmpr_req_type r,
                               input logic [pmpr_pkg::ADDR_W-1:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction

  function automatic logic [pmpr_pkg::DATA_W-1:0] word_of(
      input logic [pmpr_pkg::CODE_W-1:0] code);
    word_of = {code, 8'h00};
  endfunction

  logic [pmpr_pkg::CODE_W-1:0] out_code_reg [pmpr_pkg::NUM_CH];
  logic [pmpr_pkg::CODE_W-1:0] out_code_next [pmpr_pkg::NUM_CH];
  logic [pmpr_pkg::CODE_W-1:0] stage_code_reg [pmpr_pkg::NUM_CH];
  logic [pmpr_pkg::CODE_W-1:0] stage_code_next [pmpr_pkg::NUM_CH];
  logic [pmpr_pkg::CODE_W-1:0] bcast_out_reg;
  logic [pmpr_pkg::CODE_W-1:0] bcast_stage_reg;
  logic [pmpr_pkg::CTRL_W-1:0] select_reg;
  logic [pmpr_pkg::CTRL_W-1:0] mask_reg;
  logic strobe_prev_reg;
  pmpr_pkg::pmpr_rsp_type rsp_reg;
  pmpr_pkg::pmpr_rsp_type rsp_next;

  wire [pmpr_pkg::CODE_W-1:0] wr_code = req_in.data[pmpr_pkg::CODE_HI:pmpr_pkg::CODE_LO];
  wire [pmpr_pkg::CTRL_W-1:0] wr_ctrl = req_in.data[pmpr_pkg::CTRL_W-1:0];
  wire wr_bcast_out = hit(req_in, pmpr_pkg::OFS_BCAST_OUTPUT);
  wire wr_bcast_stage = hit(req_in, pmpr_pkg::OFS_BCAST_STAGED);
  wire wr_select = hit(req_in, pmpr_pkg::OFS_CH_SELECT);
  wire wr_mask = hit(req_in, pmpr_pkg::OFS_STROBE_MASK);
  wire wr_soft = hit(req_in, pmpr_pkg::OFS_SOFT_LOAD);
  // R10 strobe falling edge
  wire strobe_fall = strobe_prev_reg && !load_strobe_n_in;

  ////////////////////////////////////////////////////////////////////////////////
  // Per-channel output and staged registers.

  for (genvar i = 0; i < pmpr_pkg::NUM_CH; i++) begin : g_ch
    wire wr_direct_out = hit(req_in, pmpr_pkg::OFS_OUTPUT[i]);
    wire wr_direct_stage = hit(req_in, pmpr_pkg::OFS_STAGED[i]);
    // R04 R05 R06 select gating
    wire page_out = wr_bcast_out && select_reg[i];
    wire page_stage = wr_bcast_stage && select_reg[i];
    // R08 R09 soft load bit
    wire soft_load = wr_soft && wr_ctrl[i];
    // R10 mask gating
    wire strobe_load = strobe_fall && !mask_reg[i];
    // R01 R02 R03 output update
    assign out_code_next[i] = (wr_direct_out || page_out) ? wr_code :
                              (soft_load || strobe_load) ? stage_code_reg[i] :
                              out_code_reg[i];
    // R07 staged update
    assign stage_code_next[i] = (wr_direct_stage || page_stage) ? wr_code : stage_code_reg[i];

    always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        out_code_reg[i] <= pmpr_pkg::RST_CODE;
        stage_code_reg[i] <= pmpr_pkg::RST_CODE;
      end else begin
        out_code_reg[i] <= out_code_next[i];
        stage_code_reg[i] <= stage_code_next[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared registers and read path.

  // Page words are kept so they read back what was written last.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bcast_out_reg <= pmpr_pkg::RST_CODE;
      bcast_stage_reg <= pmpr_pkg::RST_CODE;
      select_reg <= pmpr_pkg::RST_CTRL;
      mask_reg <= pmpr_pkg::RST_CTRL;
      strobe_prev_reg <= 1'b1;
    end else begin
      if (wr_bcast_out) begin
        bcast_out_reg <= wr_code;
      end
      if (wr_bcast_stage) begin
        bcast_stage_reg <= wr_code;
      end
      if (wr_select) begin
        select_reg <= wr_ctrl;
      end
      if (wr_mask) begin
        mask_reg <= wr_ctrl;
      end
      strobe_prev_reg <= load_strobe_n_in;
    end
  end

  // R11 reserved bits zero
  always_comb begin
    rsp_next.valid = req_in.rd;
    rsp_next.data = pmpr_pkg::RST_WORD;
    if (req_in.rd) begin
      case (req_in.addr)
        pmpr_pkg::OFS_STROBE_MASK: rsp_next.data = {22'h00000, mask_reg};
        pmpr_pkg::OFS_CH0_OUTPUT: rsp_next.data = word_of(out_code_reg[0]);
        pmpr_pkg::OFS_CH1_OUTPUT: rsp_next.data = word_of(out_code_reg[1]);
        pmpr_pkg::OFS_BCAST_OUTPUT: rsp_next.data = word_of(bcast_out_reg);
        pmpr_pkg::OFS_CH_SELECT: rsp_next.data = {22'h00000, select_reg};
        pmpr_pkg::OFS_BCAST_STAGED: rsp_next.data = word_of(bcast_stage_reg);
        pmpr_pkg::OFS_CH0_STAGED: rsp_next.data = word_of(stage_code_reg[0]);
        pmpr_pkg::OFS_CH1_STAGED: rsp_next.data = word_of(stage_code_reg[1]);
        default: rsp_next.data = pmpr_pkg::RST_WORD;
      endcase
    end
  end

  // The soft load bits are never stored, so they read as zero and clear themselves.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  assign rsp_out = rsp_reg;
  assign channel0_code_out = out_code_reg[0];
  assign channel1_output_code_out = out_code_reg[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  property p_ch1_direct;
    hit(req_in, pmpr_pkg::OFS_CH1_OUTPUT)
    |=> channel1_output_code_out == $past(wr_code);
  endproperty
  a_ch1_direct: assert property (p_ch1_direct) else $error("ch1 direct write lost"); // R01

  property p_page_out0;
    wr_bcast_out && select_reg[0] |=> channel0_code_out == $past(wr_code);
  endproperty
  a_page_out0: assert property (p_page_out0) else $error("page write missed ch0"); // R02

  property p_page_both;
    wr_bcast_out && select_reg == 2'h3
    |=> channel0_code_out == channel1_output_code_out && channel1_output_code_out == $past(wr_code);
  endproperty
  a_page_both: assert property (p_page_both) else $error("page write not on both"); // R03

  property p_no_select;
    wr_bcast_out && select_reg == 2'h0 && !strobe_fall
    |=> $stable(channel0_code_out) && $stable(channel1_output_code_out);
  endproperty
  a_no_select: assert property (p_no_select) else $error("unselected channel moved"); // R04

  property p_stage1;
    wr_bcast_stage && select_reg[1] |=> stage_code_reg[1] == $past(wr_code);
  endproperty
  a_stage1: assert property (p_stage1) else $error("staged page missed ch1"); // R05

  property p_sel0_clear;
    wr_bcast_out && !select_reg[0] && !strobe_fall |=> $stable(channel0_code_out);
  endproperty
  a_sel0_clear: assert property (p_sel0_clear) else $error("ch0 touched while clear"); // R06

  property p_stage_only;
    wr_bcast_stage && !strobe_fall
    |=> $stable(channel0_code_out) && $stable(channel1_output_code_out);
  endproperty
  a_stage_only: assert property (p_stage_only) else $error("staged page hit output"); // R07

  property p_soft1;
    wr_soft && wr_ctrl[1] |=> channel1_output_code_out == $past(stage_code_reg[1]);
  endproperty
  a_soft1: assert property (p_soft1) else $error("soft load ch1 failed"); // R08

  property p_soft_zero;
    wr_soft && wr_ctrl == 2'h0 && !strobe_fall
    |=> $stable(channel0_code_out) && $stable(channel1_output_code_out);
  endproperty
  a_soft_zero: assert property (p_soft_zero) else $error("soft load zero acted"); // R09

  property p_strobe_mask;
    strobe_fall && mask_reg[1] && !req_in.wr |=> $stable(channel1_output_code_out);
  endproperty
  a_strobe_mask: assert property (p_strobe_mask) else $error("masked strobe loaded"); // R10

  property p_strobe_load;
    strobe_fall && !mask_reg[0] && !req_in.wr |=> channel0_code_out == $past(stage_code_reg[0]);
  endproperty
  a_strobe_load: assert property (p_strobe_load) else $error("strobe load ch0 failed"); // R10

  property p_reserved;
    req_in.rd && req_in.addr == pmpr_pkg::OFS_BCAST_STAGED |=> rsp_out.data[7:0] == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved byte nonzero"); // R11

  property p_ch1_readback;
    req_in.rd && req_in.addr == pmpr_pkg::OFS_CH1_OUTPUT
    |=> rsp_out.valid && rsp_out.data == {$past(channel1_output_code_out), 8'h00};
  endproperty
  a_ch1_readback: assert property (p_ch1_readback) else $error("ch1 readback wrong"); // R01

  property p_page_out1;
    wr_bcast_out && select_reg[1] |=> channel1_output_code_out == $past(wr_code);
  endproperty
  a_page_out1: assert property (p_page_out1) else $error("page write missed ch1"); // R05

  property p_stage0;
    wr_bcast_stage && select_reg[0] |=> stage_code_reg[0] == $past(wr_code);
  endproperty
  a_stage0: assert property (p_stage0) else $error("staged page missed ch0"); // R06

  property p_sel1_clear;
    wr_bcast_out && !select_reg[1] && !strobe_fall |=> $stable(channel1_output_code_out);
  endproperty
  a_sel1_clear: assert property (p_sel1_clear) else $error("ch1 touched while clear"); // R05

  property p_stage_unsel1;
    wr_bcast_stage && !select_reg[1] |=> $stable(stage_code_reg[1]);
  endproperty
  a_stage_unsel1: assert property (p_stage_unsel1) else $error("ch1 staged touched"); // R05

  property p_stage_unsel0;
    wr_bcast_stage && !select_reg[0] |=> $stable(stage_code_reg[0]);
  endproperty
  a_stage_unsel0: assert property (p_stage_unsel0) else $error("ch0 staged touched"); // R06

  property p_soft0;
    wr_soft && wr_ctrl[0] |=> channel0_code_out == $past(stage_code_reg[0]);
  endproperty
  a_soft0: assert property (p_soft0) else $error("soft load ch0 failed"); // R08

  property p_soft_read;
    req_in.rd && req_in.addr == pmpr_pkg::OFS_SOFT_LOAD
    |=> rsp_out.valid && rsp_out.data == 24'h000000;
  endproperty
  a_soft_read: assert property (p_soft_read) else $error("soft load bits kept"); // R09

  property p_strobe_mask0;
    strobe_fall && mask_reg[0] && !req_in.wr |=> $stable(channel0_code_out);
  endproperty
  a_strobe_mask0: assert property (p_strobe_mask0) else $error("masked strobe loaded ch0"); // R10

  property p_strobe_load1;
    strobe_fall && !mask_reg[1] && !req_in.wr
    |=> channel1_output_code_out == $past(stage_code_reg[1]);
  endproperty
  a_strobe_load1: assert property (p_strobe_load1) else $error("strobe load ch1 failed"); // R10

  property p_select_write;
    wr_select |=> select_reg == $past(wr_ctrl);
  endproperty
  a_select_write: assert property (p_select_write) else $error("select not stored"); // R04

  property p_ctrl_reserved;
    req_in.rd && req_in.addr == pmpr_pkg::OFS_CH_SELECT
    |=> rsp_out.data[pmpr_pkg::DATA_W-1:pmpr_pkg::CTRL_W] == 22'h00000;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("select upper bits set"); // R11

  property p_read_pulse;
    req_in.rd |=> rsp_out.valid;
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("read not answered"); // R01

  property p_idle_zero;
    !req_in.rd |=> !rsp_out.valid && rsp_out.data == 24'h000000;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("idle response not zero"); // R11

  c_page_both: cover property (wr_bcast_out && select_reg == 2'h3);
  c_soft_both: cover property (wr_soft && wr_ctrl == 2'h3);
  c_strobe: cover property (strobe_fall && mask_reg == 2'h0);
  c_stage_then_load: cover property (wr_bcast_stage ##[1:5] strobe_fall);
  c_masked_strobe: cover property (strobe_fall && mask_reg == 2'h3);

endmodule

`default_nettype wire

// ===== verif/pmpr_host.sv
// Purpose: Host side model that issues register accesses one at a time.
// Assumes: A request is taken on the edge after it is raised.
// Notes: Idle lines carry the inverted address and data of the last request with wr and rd low, never a stale copy.
`timescale 1ns/1ps
`default_nettype none
module pmpr_host (
  input wire logic clk_in,
  input wire pmpr_pkg::pmpr_rsp_type rsp_in,
  output var pmpr_pkg::pmpr_req_type req_out
);
  initial req_out = '0;
  ////////////////////////////////////////////////////////////////////////
  task automatic access(input logic w, input logic [7:0] a, input logic [23:0] d,
                        output logic [24:0] r);
    @(posedge clk_in);
    req_out <= {w, ~w, a, d};
    @(posedge clk_in);
    req_out <= {2'h0, ~a, ~d};
    #1;
    r = {rsp_in.valid, rsp_in.data};
  endtask
endmodule
`default_nettype wire

// ===== verif/precision_mode_page_registers_tb.sv
// Purpose: Random register traffic compared against an integer model.
// Assumes: Read answer is registered on the taking edge and sampled 1 ns later.
// Notes: The strobe is pulsed for one cycle so every pulse is a fresh edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module precision_mode_page_registers_tb;
  logic clk_in = 0;
  logic rstn_in = 0;
  logic strobe_n = 1;
  pmpr_pkg::pmpr_req_type req;
  pmpr_pkg::pmpr_rsp_type rsp;
  logic [15:0] c0, c1;
  logic [24:0] r;
  logic [23:0] d;
  logic [7:0] adr [9] = '{8'h3b, 8'h41, 8'h3e, 8'h42, 8'h45, 8'h37, 8'h38, 8'h49, 8'h46};
  int num_errors = 0, n_tests = 0, seed = 41, op;
  int outc [2], stg [2], sel, msk, pgo, pgs;
  int exp_q [$];
  pmpr_host host (.clk_in(clk_in), .rsp_in(rsp), .req_out(req));
  pmpr_regs dut (.clk_in(clk_in), .rstn_in(rstn_in), .req_in(req),
    .load_strobe_n_in(strobe_n), .rsp_out(rsp), .channel0_code_out(c0),
    .channel1_output_code_out(c1));
  initial forever #12.5 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////
  task automatic check_outs;
    `CHK(c0, 16'(outc[0]))
    `CHK(c1, 16'(outc[1]))
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] v);
    host.access(1'b1, a, v, r);
    for (int i = 0; i < 2; i++) begin
      if (a == pmpr_pkg::OFS_OUTPUT[i]) outc[i] = v[23:8];
      if (a == pmpr_pkg::OFS_STAGED[i]) stg[i] = v[23:8];
      if (a == 8'h3e && sel[i]) outc[i] = v[23:8];
      if (a == 8'h42 && sel[i]) stg[i] = v[23:8];
      if (a == 8'h45 && v[i]) outc[i] = stg[i];
    end
    if (a == 8'h41) sel = v[1:0];
    if (a == 8'h37) msk = v[1:0];
    if (a == 8'h3e) pgo = v[23:8];
    if (a == 8'h42) pgs = v[23:8];
    check_outs;
  endtask
  function automatic logic [23:0] exp_of(input logic [7:0] a);
    case (a)
      8'h37: exp_of = 24'(msk);
      8'h38: exp_of = 24'(outc[0] << 8);
      8'h3b: exp_of = 24'(outc[1] << 8);
      8'h3e: exp_of = 24'(pgo << 8);
      8'h41: exp_of = 24'(sel);
      8'h42: exp_of = 24'(pgs << 8);
      8'h46: exp_of = 24'(stg[0] << 8);
      8'h49: exp_of = 24'(stg[1] << 8);
      default: exp_of = 24'h000000;
    endcase
  endfunction
  task automatic rd(input logic [7:0] a, input logic [23:0] e);
    logic [24:0] want;
    exp_q.push_back(e);
    host.access(1'b0, a, 24'h000000, r);
    want = {1'b1, 24'(exp_q.pop_front())};
    `CHK(r, want)
  endtask
  task automatic pulse;
    @(posedge clk_in);
    strobe_n <= 1'b0;
    @(posedge clk_in);
    strobe_n <= 1'b1;
    #1;
    for (int i = 0; i < 2; i++) if (!msk[i]) outc[i] = stg[i];
    check_outs;
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(8'h3b, 24'h000000);
    rd(8'h41, 24'h000000);
    rd(8'h45, 24'h000000);
    rd(8'h00, 24'h000000);
    wr(8'h3e, 24'h5a5aff);
    wr(8'h42, 24'ha5a5ff);
    pulse;
    wr(8'h41, 24'h000003);
    wr(8'h3e, 24'h1234ff);
    for (int i = 0; i < 80; i++) begin
      op = $unsigned($random(seed)) % 10;
      d = 24'($random(seed));
      if (op == 9) pulse;
      else wr(adr[op], d);
      rd(8'h3b, 24'(outc[1] << 8));
      rd(8'h41, 24'(sel));
      op = $unsigned($random(seed)) % 9;
      rd(adr[op], exp_of(adr[op]));
    end
    give_verdict;
  end
endmodule
`default_nettype wire
